// file: prq_consts.svh
// Constants for the prefetch request queue
`ifndef PRQ_CONSTS_SVH
`define PRQ_CONSTS_SVH
`define PRQ_NUM_BUFS      6
`define PRQ_ADDR_W        32
`define PRQ_LINE_BYTES    64
`define PRQ_OFFS_W        6
`define PRQ_IDX_W         3
`define PRQ_MESI_MODIFIED 2'h3
`define PRQ_MESI_EXCL     2'h2
`endif

// file: prq_pkg.sv
// Types shared by the prefetch request queue
`default_nettype none
package prq_pkg;
  `include "prq_consts.svh"

  typedef logic [`PRQ_ADDR_W-`PRQ_OFFS_W-1:0] prq_line_t;

  // Hint from the pipeline
  typedef struct packed {
    logic      valid;
    logic      write_intent;
    logic [`PRQ_ADDR_W-1:0] addr;
  } prq_hint_t;

  // Request to memory
  typedef struct packed {
    logic      valid;
    logic [`PRQ_IDX_W-1:0] tag;
    logic [`PRQ_ADDR_W-1:0] addr;
  } prq_mreq_t;

  // Fill install order to the cache
  typedef struct packed {
    logic      valid;
    logic [1:0] state;
    logic [`PRQ_ADDR_W-1:0] addr;
  } prq_inst_t;

  // One outstanding-request buffer
  typedef struct packed {
    logic      busy;
    logic      sent;
    logic      write_intent;
    prq_line_t line;
  } prq_buf_t;
endpackage
`default_nettype wire

// file: prq_order_fifo.sv
// Issue-order ring of buffer indices awaiting dispatch
`timescale 1ns/100ps
`default_nettype none
module prq_order_fifo #(
  parameter int DEPTH = 6,
  parameter int IW    = 3
) (
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          push_i,
  input  wire logic [IW-1:0] push_idx_i,
  input  wire logic          pop_i,
  output logic               empty_o,
  output logic [IW-1:0]      head_o
);
  typedef struct packed {
    logic [DEPTH-1:0][IW-1:0] mem;
    logic [IW-1:0]            rd;
    logic [IW-1:0]            wr;
    logic [IW:0]              cnt;
  } prqf_state_t;

  prqf_state_t s_reg;
  prqf_state_t s_next;

  // Wrap a pointer at DEPTH, which need not be a power of two
  function automatic logic [IW-1:0] bump(input logic [IW-1:0] p);
    bump = (p == IW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Never overflows: one entry per busy buffer at most
  always_comb begin
    s_next = s_reg;
    if (push_i) begin
      s_next.mem[s_reg.wr] = push_idx_i;
      s_next.wr = bump(s_reg.wr);
    end
    if (pop_i) begin
      s_next.rd = bump(s_reg.rd);
    end
    s_next.cnt = s_reg.cnt + (IW+1)'(push_i) - (IW+1)'(pop_i);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign empty_o = (s_reg.cnt == '0);
  assign head_o  = s_reg.mem[s_reg.rd];
endmodule
`default_nettype wire

// file: prq_top.sv
// Software prefetch request tracker of the load/store unit
`timescale 1ns/100ps
`default_nettype none
`include "prq_consts.svh"
module prq_top #(
  parameter int NUM_BUFS = `PRQ_NUM_BUFS
) (
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       NRST_I,
  input  wire prq_pkg::prq_hint_t         HINT_I,
  input  wire logic                       CACHE_HIT_I,
  input  wire logic                       STORE_PEND_I,
  input  wire logic [`PRQ_ADDR_W-1:0]     STORE_ADDR_I,
  input  wire logic                       MEM_READY_I,
  input  wire logic                       FILL_VALID_I,
  input  wire logic [`PRQ_IDX_W-1:0]      FILL_TAG_I,
  output prq_pkg::prq_mreq_t              MEM_REQ_O,
  output prq_pkg::prq_inst_t              INSTALL_O,
  output logic                            RETIRE_O,
  output logic                            DROP_O,
  output logic [`PRQ_NUM_BUFS-1:0]        BUSY_O
);
  import prq_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum {PRQ_IDLE, PRQ_WAIT} prq_disp_t;

  typedef struct packed {
    prq_buf_t [NUM_BUFS-1:0] bufs;
    prq_mreq_t               mreq;
    prq_inst_t               inst;
    logic                    retire;
    logic                    drop;
  } prq_state_t;

  prq_state_t s_reg;
  prq_state_t s_next;
  prq_disp_t  disp_reg;
  prq_disp_t  disp_next;

  logic                  fifo_empty;
  logic [`PRQ_IDX_W-1:0] fifo_head;
  logic                  push;
  logic                  pop;
  logic [`PRQ_IDX_W-1:0] free_idx;

  // Line number of a byte address, offset bits dropped
  function automatic prq_line_t line_of(input logic [`PRQ_ADDR_W-1:0] a);
    line_of = a[`PRQ_ADDR_W-1:`PRQ_OFFS_W];
  endfunction

  // Byte address of a line, aligned to its boundary
  function automatic logic [`PRQ_ADDR_W-1:0] addr_of(input prq_line_t l);
    addr_of = {l, `PRQ_OFFS_W'(0)};
  endfunction

  // ************************************************************
  // Allocation and completion
  // ************************************************************
  // Dup, full and free-slot search on the incoming hint
  logic hint_dup;
  logic any_free;
  always_comb begin
    hint_dup = 1'b0;
    any_free = 1'b0;
    free_idx = '0;
    for (int i = NUM_BUFS - 1; i >= 0; i--) begin
      if (s_reg.bufs[i].busy &&
          s_reg.bufs[i].line == line_of(HINT_I.addr)) begin
        hint_dup = 1'b1;
      end
      if (!s_reg.bufs[i].busy) begin
        any_free = 1'b1;
        free_idx = `PRQ_IDX_W'(i);
      end
    end
  end

  // Allocate only on a miss with a free slot; drop never stalls
  assign push = HINT_I.valid && !CACHE_HIT_I && !hint_dup
                && any_free;

  // Dispatch head when no shown request waits for MEM_READY_I and no store blocks its line
  logic head_blocked;
  always_comb begin
    head_blocked = STORE_PEND_I &&
      line_of(STORE_ADDR_I) == s_reg.bufs[fifo_head].line;
  end
  assign pop = (disp_reg == PRQ_IDLE) && !fifo_empty
               && !head_blocked;

  // Main next-state logic
  always_comb begin
    s_next = s_reg;
    disp_next = disp_reg;
    s_next.inst.valid = 1'b0;
    // Retire every hint at once; no register is ever written back
    s_next.retire = HINT_I.valid;
    s_next.drop = HINT_I.valid && !CACHE_HIT_I && !hint_dup
                  && !any_free;
    // Request handshake: hold until MEM_READY_I takes it
    case (disp_reg)
      PRQ_IDLE: begin
        if (pop) begin
          s_next.mreq.valid = 1'b1;
          s_next.mreq.tag = fifo_head;
          s_next.mreq.addr =
            addr_of(s_reg.bufs[fifo_head].line);
          s_next.bufs[fifo_head].sent = 1'b1;
          disp_next = PRQ_WAIT;
        end
      end
      PRQ_WAIT: begin
        if (MEM_READY_I) begin
          s_next.mreq.valid = 1'b0;
          disp_next = PRQ_IDLE;
        end
      end
      default: begin
        disp_next = PRQ_IDLE;
      end
    endcase
    // Fill completes: install line, free its buffer
    if (FILL_VALID_I && s_reg.bufs[FILL_TAG_I].busy) begin
      s_next.inst.valid = 1'b1;
      s_next.inst.addr = addr_of(s_reg.bufs[FILL_TAG_I].line);
      s_next.inst.state = s_reg.bufs[FILL_TAG_I].write_intent
        ? `PRQ_MESI_MODIFIED : `PRQ_MESI_EXCL;
      s_next.bufs[FILL_TAG_I].busy = 1'b0;
      s_next.bufs[FILL_TAG_I].sent = 1'b0;
    end
    // Allocation after release: free_idx is never the filling slot
    if (push) begin
      s_next.bufs[free_idx].busy = 1'b1;
      s_next.bufs[free_idx].sent = 1'b0;
      s_next.bufs[free_idx].write_intent = HINT_I.write_intent;
      s_next.bufs[free_idx].line = line_of(HINT_I.addr);
    end
  end

  // Registers
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      s_reg <= '0;
      disp_reg <= PRQ_IDLE;
    end else begin
      s_reg <= s_next;
      disp_reg <= disp_next;
    end
  end

  // ************************************************************
  // Issue order
  // ************************************************************
  // Index ring keeps the pipeline order for dispatch
  prq_order_fifo #(
    .DEPTH (NUM_BUFS),
    .IW    (`PRQ_IDX_W)
  ) u_order (
    .clk_i      (CORE_CLK_I),
    .nrst_i     (NRST_I),
    .push_i     (push),
    .push_idx_i (free_idx),
    .pop_i      (pop),
    .empty_o    (fifo_empty),
    .head_o     (fifo_head)
  );

  // Outputs straight from flip-flops
  always_comb begin
    for (int i = 0; i < NUM_BUFS; i++) begin
      BUSY_O[i] = s_reg.bufs[i].busy;
    end
  end
  assign MEM_REQ_O = s_reg.mreq;
  assign INSTALL_O = s_reg.inst;
  assign RETIRE_O  = s_reg.retire;
  assign DROP_O    = s_reg.drop;
endmodule
`default_nettype wire

// file: prq_checker.sv
// Assertion checker for the prefetch request queue
`timescale 1ns/100ps
`default_nettype none
`include "prq_consts.svh"
module prq_checker #(
  parameter int NUM_BUFS = 6
) (
  input wire logic                   CORE_CLK_I,
  input wire logic                   NRST_I,
  input wire prq_pkg::prq_hint_t     HINT_I,
  input wire logic                   CACHE_HIT_I,
  input wire logic                   STORE_PEND_I,
  input wire logic [`PRQ_ADDR_W-1:0] STORE_ADDR_I,
  input wire logic                   MEM_READY_I,
  input wire logic                   FILL_VALID_I,
  input wire logic [`PRQ_IDX_W-1:0]  FILL_TAG_I,
  input wire prq_pkg::prq_mreq_t     MEM_REQ_O,
  input wire prq_pkg::prq_inst_t     INSTALL_O,
  input wire logic                   RETIRE_O,
  input wire logic                   DROP_O,
  input wire logic [`PRQ_NUM_BUFS-1:0] BUSY_O
);
  import prq_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_ret; HINT_I.valid |=> RETIRE_O; endproperty
  a_ret: assert property (p_ret) else $error("no retire");
  property p_drop; DROP_O |-> $past(&BUSY_O); endproperty
  a_drop: assert property (p_drop) else $error("bad drop");
  property p_align; MEM_REQ_O.valid |-> MEM_REQ_O.addr[5:0] == 6'h00;
  endproperty
  a_align: assert property (p_align) else $error("unaligned");
  // A shown request waits for memory, whatever the store side does
  property p_hold; MEM_REQ_O.valid && !MEM_READY_I
    |=> MEM_REQ_O.valid && $stable(MEM_REQ_O); endproperty
  a_hold: assert property (p_hold) else $error("req moved");
  property p_gap; MEM_REQ_O.valid && MEM_READY_I |=> !MEM_REQ_O.valid;
  endproperty
  a_gap: assert property (p_gap) else $error("req gap");
  property p_inst; FILL_VALID_I && BUSY_O[FILL_TAG_I]
    |=> INSTALL_O.valid && !BUSY_O[$past(FILL_TAG_I)]; endproperty
  a_inst: assert property (p_inst) else $error("no install");
  property p_hit; HINT_I.valid && CACHE_HIT_I && !FILL_VALID_I
    |=> BUSY_O == $past(BUSY_O); endproperty
  a_hit: assert property (p_hit) else $error("hit took buf");
  property p_st; $rose(MEM_REQ_O.valid) |-> !($past(STORE_PEND_I) &&
    $past(STORE_ADDR_I[31:6]) == MEM_REQ_O.addr[31:6]); endproperty
  a_st: assert property (p_st) else $error("store bypass");
endmodule
bind prq_top prq_checker #(.NUM_BUFS(NUM_BUFS)) prq_checker_inst (
  .CORE_CLK_I   (CORE_CLK_I),
  .NRST_I       (NRST_I),
  .HINT_I       (HINT_I),
  .CACHE_HIT_I  (CACHE_HIT_I),
  .STORE_PEND_I (STORE_PEND_I),
  .STORE_ADDR_I (STORE_ADDR_I),
  .MEM_READY_I  (MEM_READY_I),
  .FILL_VALID_I (FILL_VALID_I),
  .FILL_TAG_I   (FILL_TAG_I),
  .MEM_REQ_O    (MEM_REQ_O),
  .INSTALL_O    (INSTALL_O),
  .RETIRE_O     (RETIRE_O),
  .DROP_O       (DROP_O),
  .BUSY_O       (BUSY_O)
);
`default_nettype wire

// file: prq_pipe_model.sv
// Pipeline model that issues prefetch hints
`timescale 1ns/100ps
`default_nettype none
module prq_pipe_model (
  input  wire logic       clk_i,
  output prq_pkg::prq_hint_t hint_o,
  output logic            hit_o
);
  import prq_pkg::*;
  initial begin
    hint_o = '0;
    hit_o  = 1'b0;
  end
  // Called at a falling edge; held for one cycle, no release
  task automatic issue(input logic [31:0] a, input logic wi,
                       input logic hit);
    hint_o = '{1'b1, wi, a};
    hit_o  = hit;
    @(negedge clk_i);
  endtask
  // Idle: address turned over so a stale value never looks held
  task automatic idle();
    hint_o.valid = 1'b0;
    hint_o.addr  = ~hint_o.addr;
    hit_o        = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the prefetch request queue
`timescale 1ns/100ps
`default_nettype none
module tb;
  import prq_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, spend = 1'b0, rdy = 1'b0, fv = 1'b0;
  logic [31:0] saddr = '0;
  logic [2:0]  ftag = '0;
  logic [5:0]  busy;
  logic        hit, ret, drop;
  prq_hint_t   hint;
  prq_mreq_t   mreq;
  prq_inst_t   inst;
  int fails = 0, n_compared = 0;
  always #5 clk = ~clk;
  prq_pipe_model prq_pipe_model_inst (.clk_i(clk), .hint_o(hint),
    .hit_o(hit));
  prq_top prq_top_inst (.CORE_CLK_I(clk), .NRST_I(nrst), .HINT_I(hint),
    .CACHE_HIT_I(hit), .STORE_PEND_I(spend), .STORE_ADDR_I(saddr),
    .MEM_READY_I(rdy), .FILL_VALID_I(fv), .FILL_TAG_I(ftag),
    .MEM_REQ_O(mreq), .INSTALL_O(inst), .RETIRE_O(ret),
    .DROP_O(drop), .BUSY_O(busy));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits a bounded time for the head request, then takes it
  task automatic take(input logic [31:0] a, input logic [2:0] t);
    for (int i = 0; i < 20 && !mreq.valid; i++) @(negedge clk);
    chk({mreq.valid, mreq.tag, mreq.addr}, {1'b1, t, a});
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
  endtask
  task automatic fill(input logic [2:0] t);
    fv = 1'b1;
    ftag = t;
    @(negedge clk);
    fv = 1'b0;
    ftag = ~t;
  endtask
  task automatic t_line(input logic wi);
    prq_pipe_model_inst.issue(32'h1000_0047, wi, 1'b0);
    prq_pipe_model_inst.idle();
    chk({ret, busy}, {1'b1, 6'h01});
    take(32'h1000_0040, 3'h0);
    fill(3'h0);
    chk(inst, {1'b1, wi ? 2'h3 : 2'h2, 32'h1000_0040});
    chk(busy, 6'h00);
  endtask
  task automatic t_hit();
    prq_pipe_model_inst.issue(32'h2000_0000, 1'b0, 1'b1);
    prq_pipe_model_inst.idle();
    chk({ret, busy}, {1'b1, 6'h00});
  endtask
  task automatic t_store();
    spend = 1'b1;
    saddr = 32'h3000_0088;
    prq_pipe_model_inst.issue(32'h3000_00b0, 1'b1, 1'b0);
    prq_pipe_model_inst.idle();
    repeat (5) @(negedge clk);
    chk(mreq.valid, 1'b0);
    spend = 1'b0;
    take(32'h3000_0080, 3'h0);
    fill(3'h0);
  endtask
  // Same line twice: one buffer; a store to another line blocks nothing
  task automatic t_dup();
    spend = 1'b1;
    saddr = 32'h6000_0040;
    prq_pipe_model_inst.issue(32'h6000_0000, 1'b0, 1'b0);
    prq_pipe_model_inst.issue(32'h6000_0030, 1'b1, 1'b0);
    prq_pipe_model_inst.idle();
    chk({ret, busy, mreq.valid}, {1'b1, 6'h01, 1'b1});
    spend = 1'b0;
    take(32'h6000_0000, 3'h0);
    fill(3'h0);
    chk(inst, {1'b1, 2'h2, 32'h6000_0000});
    chk(busy, 6'h00);
  endtask
  // Mid-run reset clears everything; a hint right after it allocates
  task automatic t_reset();
    nrst = 1'b0;
    @(negedge clk);
    chk({mreq.valid, inst.valid, ret, drop, busy}, '0);
    nrst = 1'b1;
    prq_pipe_model_inst.issue(32'h7000_0010, 1'b0, 1'b0);
    prq_pipe_model_inst.idle();
    chk({ret, busy}, {1'b1, 6'h01});
  endtask
  task automatic t_full();
    for (int i = 0; i < 7; i++)
      prq_pipe_model_inst.issue(32'h4000_0000 + 64 * i, 1'b0, 1'b0);
    prq_pipe_model_inst.idle();
    chk({drop, busy}, {1'b1, 6'h3f});
    for (int i = 0; i < 6; i++) take(32'h4000_0000 + 64 * i, 3'(i));
    fill(3'h3);
    chk(busy, 6'h37);
    prq_pipe_model_inst.issue(32'h5000_0000, 1'b0, 1'b0);
    prq_pipe_model_inst.idle();
    chk({drop, busy}, {1'b0, 6'h3f});
    @(negedge clk);
    chk(busy, 6'h3f);
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_line(1'b0);
    t_line(1'b1);
    t_hit();
    t_store();
    t_dup();
    t_full();
    t_reset();
    results();
  end
  // Whole run is under a hundred cycles
  initial begin
    #50000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
